// ==== spi_regs.svh ====
`ifndef SPI_REGS_SVH
`define SPI_REGS_SVH

// command word fields: one word per sequencer slot
`define CMD_DIV     10:0
`define CMD_CPOL    11
`define CMD_CPHA    12
`define CMD_LEN     16:13
`define CMD_LSB     17
`define CMD_BURST   18
`define CMD_SSL     20:19
`define CMD_CKDLY   23:21
`define CMD_NEGDLY  26:24
`define CMD_NXTDLY  29:27
`define CMD_RESET   32'h0000_0000

// frame length codes above the 8..16 range (codes 0..8)
`define LEN_MAX_LIN 4'h8
`define LEN_20      4'h9
`define LEN_24      4'hA
`define LEN_32      4'hB

// storage sizes
`define BUF_DEPTH   4
`define WORD_BITS   32
`define CMD_SLOTS   8

// status flag positions
`define FLAG_MODF   0
`define FLAG_OVR    1
`define FLAG_UDR    2
`define FLAG_PAR    3

// select line output enables per master mode
`define SSL_OE_SINGLE 4'hF
`define SSL_OE_MULTI  4'hE

`endif

// ==== spi_types_pkg.sv ====
package spi_types_pkg;
  `include "spi_regs.svh"

  // gray path: idle -> ck delay -> transfer -> neg delay -> next delay
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_CKDLY  = 3'h1,
    ST_XFER   = 3'h3,
    ST_NEGDLY = 3'h2,
    ST_NXTDLY = 3'h6
  } state_type;

  // frame length in bits from a length code; unknown codes fall to 8
  function automatic logic [5:0] frame_bits(input logic [3:0] code);
    if (code <= `LEN_MAX_LIN) frame_bits = 6'h08 + {2'h0, code};
    else if (code == `LEN_20) frame_bits = 6'h14;
    else if (code == `LEN_24) frame_bits = 6'h18;
    else if (code == `LEN_32) frame_bits = 6'h20;
    else frame_bits = 6'h08;
  endfunction : frame_bits

  function automatic logic [31:0] rev32(input logic [31:0] w);
    for (int i = 0; i < 32; i++) rev32[i] = w[31-i];
  endfunction : rev32

  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : swap32

  function automatic logic [31:0] low_mask(input logic [5:0] n);
    low_mask = (n >= 6'h20) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
  endfunction : low_mask
endpackage : spi_types_pkg

// ==== spi_fifo.sv ====
`timescale 1ns/100ps
`include "spi_regs.svh"
module spi_fifo #(
  parameter int DEPTH = `BUF_DEPTH,
  parameter int WIDTH = `WORD_BITS
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [CW-1:0]    count_r;

  // head always sits in slot 0 so the output comes straight from a flop
  wire          push      = in_valid && in_ready;
  wire          pop       = out_valid && out_ready;
  wire [CW-1:0] count_nxt = count_r + CW'(push) - CW'(pop);
  wire [CW-1:0] wr_idx    = count_r - CW'(pop);
  assign out_data = mem_r[0];

  // occupancy and registered full / empty flags
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      count_r   <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      in_ready  <= (count_nxt != CW'(DEPTH));
      out_valid <= (count_nxt != '0);
    end
  end

  // shift on pop, write behind the last live entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else begin
      for (int i = 0; i < DEPTH - 1; i++) if (pop) mem_r[i] <= mem_r[i+1];
      for (int i = 0; i < DEPTH; i++) begin
        if (push && wr_idx == CW'(i)) mem_r[i] <= in_data;
      end
    end
  end
endmodule : spi_fifo

// ==== spi_baud.sv ====
`timescale 1ns/100ps
module spi_baud (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // divider control
  input  wire logic        run,
  input  wire logic [10:0] div,
  // half serial period strobe
  output logic             tick
);
  logic [10:0] cnt_r;

  // one tick every div+1 clocks: a full serial period is 2*(div+1)
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_r <= 11'h000;
      tick  <= 1'b0;
    end else if (cnt_r == div) begin
      cnt_r <= 11'h000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 11'h001;
      tick  <= 1'b0;
    end
  end
endmodule : spi_baud

// ==== spi_port.sv ====
`timescale 1ns/100ps
`include "spi_regs.svh"
// Function
// R1: four-wire with select, or three-wire clocked mode without select; code applies three-wire to the slave only, a master still drives select.
// R2: full duplex or transmit-only, received data then discarded.
// R3: clock polarity, phase and bit order selectable per command.
// R4: frame length 8 to 16 bits, or 20, 24, 32 bits.
// R5: 128-bit transmit and receive stores, four frames of 32 bits.
// R6: optional byte swap of transmit and receive words.
// R7: master clock divides system clock by 2 up to 4096.
// R8: slave clock from the far master at most a quarter of ours.
// R9: detect mode fault, overrun, parity and underrun with flags.
// R10: single master drives all four select lines.
// R11: select 0 input in multi-master and slave; others out or unused.
// R12: one to eight serial clocks from select assert to clock start.
// R13: one to eight serial clocks from clock stop to select negate.
// R14: one to eight serial clocks before the next select assert.
// R15: each select line has its own active polarity.
// R16: looped sequence of up to eight commands, each with settings.
// R17: a word written into the transmit store starts a transfer.
// R18: with select negated, mosi sits at a software level.
// R19: auto-stop holds the clock while the receive store is full.
// R20: parity bit appended and checked only when parity enabled.
// R21: four requests: receive full, transmit empty, error, idle.
// R22: software module initialise and internal loopback mode.
// R23: overrun when a frame lands on a full store; keep old data.
module spi_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // mode and configuration
  input  wire logic        master_en,
  input  wire logic        multi_master,
  input  wire logic        three_wire,
  input  wire logic        transmit_only_select,
  input  wire logic        loopback_en,
  input  wire logic        parity_enable,
  input  wire logic        parity_odd,
  input  wire logic        clock_autostop_enable,
  input  wire logic        byte_access_select,
  input  wire logic        mosi_idle_level,
  input  wire logic [3:0]  ssl_polarity,
  input  wire logic [2:0]  seq_last,
  input  wire logic        soft_init,
  // command table write
  input  wire logic        cmd_wr,
  input  wire logic [2:0]  cmd_idx,
  input  wire logic [31:0] cmd_word,
  // transmit words
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  output logic             tx_ready,
  // receive words
  output logic             rx_valid,
  output logic      [31:0] rx_data,
  input  wire logic        rx_ready,
  // status flags
  input  wire logic [3:0]  flag_clear,
  output logic             mode_fault_flag,
  output logic             overrun_flag,
  output logic             underrun_flag,
  output logic             parity_err_flag,
  output logic             busy,
  // interrupt requests
  output logic             irq_rx_full,
  output logic             irq_tx_empty,
  output logic             irq_error,
  output logic             irq_idle,
  // serial pins
  input  wire logic        serial_clock_line_in,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        slave_select_0_in,
  output logic      [3:0]  slave_select_out,
  output logic      [3:0]  slave_select_oe
);
  spi_types_pkg::state_type state_r, state_nxt;
  logic [31:0] cmd_r [`CMD_SLOTS];
  logic [31:0] fcfg_r, rx_hold_r, tx_out_data;
  logic [32:0] txs_r, rxs_r;
  logic [5:0]  bit_cnt_r, trail_cnt_r;
  logic [3:0]  sync1_r, sync2_r, dly_cnt_r, flags_r;
  logic [2:0]  cmd_ptr_r;
  logic        sclk_prev_r, s_sel_prev_r, sclk_r, out_bit_r;
  logic        fin_r, rx_bad_r, tick, tx_out_valid, rx_in_ready;

  // pins from outside pass two flops; only the second stage is read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r     <= 4'h0;
      sync2_r     <= 4'h0;
      sclk_prev_r <= 1'b0;
    end else begin
      sync1_r     <= {slave_select_0_in, miso_in, mosi_in,
                      serial_clock_line_in};
      sync2_r     <= sync1_r;
      sclk_prev_r <= sync2_r[0];
    end
  end
  wire s_sclk = sync2_r[0];
  wire s_mosi = sync2_r[1];
  wire s_miso = sync2_r[2];
  wire s_ssl0 = sync2_r[3];

  // command slots keep their contents across soft init
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `CMD_SLOTS; i++) cmd_r[i] <= `CMD_RESET;
    end else if (cmd_wr) begin
      cmd_r[cmd_idx] <= cmd_word;  // R16
    end
  end

  // mode decode; a slave always runs from slot 0
  wire [31:0] cfg_sel   = master_en ? cmd_r[cmd_ptr_r] : cmd_r[0];
  wire        cpol      = fcfg_r[`CMD_CPOL];
  wire        cpha      = fcfg_r[`CMD_CPHA];
  wire [5:0]  n_bits    = spi_types_pkg::frame_bits(fcfg_r[`CMD_LEN]); // R4
  wire [5:0]  total     = n_bits + {5'h00, parity_enable};  // R20
  wire        ssl0_act  = (s_ssl0 == ssl_polarity[0]);  // R15
  wire        modf_set  = master_en && multi_master && ssl0_act;  // R11
  wire        master_ok = master_en && !flags_r[`FLAG_MODF] && !modf_set;
  wire        s_sel     = !master_en && (three_wire || ssl0_act);  // R1
  wire        rx_stall  = clock_autostop_enable && !rx_in_ready;  // R19
  wire        in_frame  = (state_r == spi_types_pkg::ST_CKDLY) ||
                          (state_r == spi_types_pkg::ST_XFER) ||
                          (state_r == spi_types_pkg::ST_NEGDLY);
  wire        in_xfer   = (state_r == spi_types_pkg::ST_XFER);

  // edge events: master from its own divider, slave from the pin
  wire m_lead  = tick && in_xfer && (sclk_r == cpol);
  wire m_trail = tick && in_xfer && (sclk_r != cpol);
  wire s_edge  = s_sel && (s_sclk != sclk_prev_r);
  wire s_lead  = s_edge && (sclk_prev_r == cpol);
  wire s_trail = s_edge && (sclk_prev_r != cpol);
  wire ev_lead  = master_en ? m_lead : s_lead;
  wire ev_trail = master_en ? m_trail : s_trail;
  wire sample   = cpha ? ev_trail : ev_lead;  // R3
  wire drive    = cpha ? ev_lead : (ev_trail && bit_cnt_r != 6'h00);
  wire last_sample = sample && (bit_cnt_r == total - 6'h01);
  wire m_end   = m_trail && (trail_cnt_r == total - 6'h01);

  // delay phases count half periods: 2*(d+1) ticks for a setting d
  wire [2:0] dly_sel =
    (state_r == spi_types_pkg::ST_CKDLY)  ? fcfg_r[`CMD_CKDLY] :
    (state_r == spi_types_pkg::ST_NEGDLY) ? fcfg_r[`CMD_NEGDLY] :
                                            fcfg_r[`CMD_NXTDLY];
  wire dly_done = tick && (dly_cnt_r == {dly_sel, 1'b1});

  // loads: a word into the store starts a master frame, burst chains
  wire m_load = master_ok && tx_out_valid && !rx_stall &&
                ((state_r == spi_types_pkg::ST_IDLE) ||
                 (m_end && fcfg_r[`CMD_BURST]));  // R17
  wire s_load = s_sel && (!s_sel_prev_r || last_sample);
  wire load   = m_load || s_load;
  wire tx_pop = load && tx_out_valid;
  wire udr_set = s_load && !tx_out_valid;  // R9

  // transmit image: align first bit to the top, parity right behind the last data bit
  wire [5:0]  ld_n   = spi_types_pkg::frame_bits(cfg_sel[`CMD_LEN]);
  wire [31:0] tx_w   = byte_access_select ?
                       spi_types_pkg::swap32(tx_out_data) : tx_out_data; // R6
  wire [31:0] tx_m   = tx_out_valid ?
                       (tx_w & spi_types_pkg::low_mask(ld_n)) : 32'h0000_0000;
  wire [31:0] tx_al  = cfg_sel[`CMD_LSB] ? spi_types_pkg::rev32(tx_m) :
                       (tx_m << (6'h20 - ld_n));  // R3
  wire        tx_par = (^tx_m) ^ parity_odd;
  wire [32:0] par_bt = (parity_enable && tx_par) ?
                       (33'h0_0000_0001 << (6'h20 - ld_n)) : 33'h0_0000_0000;
  wire [32:0] tx_img = {tx_al, 1'b0} | par_bt;  // R20

  // receive decode from the shift value that includes the final bit
  wire        rx_bit = loopback_en ? out_bit_r :
                       (master_en ? s_miso : s_mosi);  // R22
  wire [32:0] rxs_fin = {rxs_r[31:0], rx_bit};
  wire [31:0] rx_raw = (parity_enable ? rxs_fin[32:1] : rxs_fin[31:0]) &
                       spi_types_pkg::low_mask(n_bits);
  wire [31:0] rx_ord = fcfg_r[`CMD_LSB] ?
                       (spi_types_pkg::rev32(rx_raw) >> (6'h20 - n_bits)) :
                       rx_raw;
  wire [31:0] rx_word = byte_access_select ?
                        spi_types_pkg::swap32(rx_ord) : rx_ord;  // R6
  wire        rx_par_bad = parity_enable &&
                           (((^rx_raw) ^ rxs_fin[0]) != parity_odd); // R20

  // finished frame enters the receive store unless transmit-only
  wire rx_in_valid = fin_r && !transmit_only_select;  // R2
  wire ovr_set = rx_in_valid && !rx_in_ready;  // R23
  wire par_set = rx_in_valid && rx_bad_r;  // R20

  // serial shift engine shared by master and slave
  always_ff @(posedge clk) begin
    if (!rst_n || soft_init) begin
      fcfg_r <= `CMD_RESET;  // R22
      txs_r <= 33'h0_0000_0000;
      rxs_r <= 33'h0_0000_0000;
      rx_hold_r <= 32'h0000_0000;
      bit_cnt_r <= 6'h00;
      trail_cnt_r <= 6'h00;
      out_bit_r <= 1'b0;
      fin_r <= 1'b0;
      rx_bad_r <= 1'b0;
      s_sel_prev_r <= 1'b0;
    end else begin
      fin_r <= last_sample;
      s_sel_prev_r <= s_sel;
      if (last_sample) begin
        rx_hold_r <= rx_word;
        rx_bad_r <= rx_par_bad;
      end
      if (load) begin
        fcfg_r <= cfg_sel;  // R16
        bit_cnt_r <= 6'h00;
        trail_cnt_r <= 6'h00;
        // phase 0 puts the first bit out before the first edge
        if (cfg_sel[`CMD_CPHA]) begin
          txs_r <= tx_img;
        end else begin
          txs_r <= {tx_img[31:0], 1'b0};
          out_bit_r <= tx_img[32];
        end
      end else begin
        if (drive) begin
          out_bit_r <= txs_r[32];
          txs_r <= {txs_r[31:0], 1'b0};
        end
        if (sample && bit_cnt_r != total) begin
          rxs_r <= rxs_fin;
          bit_cnt_r <= bit_cnt_r + 6'h01;
        end
        if (ev_trail) trail_cnt_r <= trail_cnt_r + 6'h01;
      end
    end
  end

  // master sequence; mode fault or leaving master mode aborts it
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      spi_types_pkg::ST_IDLE:
        if (m_load) state_nxt = spi_types_pkg::ST_CKDLY;
      spi_types_pkg::ST_CKDLY:
        if (dly_done) state_nxt = spi_types_pkg::ST_XFER;  // R12
      spi_types_pkg::ST_XFER:
        if (m_end && !m_load) state_nxt = spi_types_pkg::ST_NEGDLY;
      spi_types_pkg::ST_NEGDLY:
        if (dly_done) state_nxt = spi_types_pkg::ST_NXTDLY;  // R13
      spi_types_pkg::ST_NXTDLY:
        if (dly_done) state_nxt = spi_types_pkg::ST_IDLE;  // R14
      default:
        state_nxt = spi_types_pkg::ST_IDLE;
    endcase
    if (!master_en || modf_set) state_nxt = spi_types_pkg::ST_IDLE;  // R9
  end

  // master clock, delay counter and command pointer
  always_ff @(posedge clk) begin
    if (!rst_n || soft_init) begin
      state_r <= spi_types_pkg::ST_IDLE;
      dly_cnt_r <= 4'h0;
      sclk_r <= 1'b0;
      cmd_ptr_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      dly_cnt_r <= (state_nxt != state_r) ? 4'h0 : dly_cnt_r + {3'h0, tick};
      if (state_r == spi_types_pkg::ST_IDLE) sclk_r <= cfg_sel[`CMD_CPOL];
      else if (m_lead || m_trail) sclk_r <= ~sclk_r;
      if (in_xfer && state_nxt == spi_types_pkg::ST_NEGDLY) begin
        cmd_ptr_r <= (cmd_ptr_r == seq_last) ? 3'h0 : cmd_ptr_r + 3'h1; // R16
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  wire [3:0] flag_set = {par_set, udr_set, ovr_set, modf_set};
  always_ff @(posedge clk) begin
    if (!rst_n || soft_init) flags_r <= 4'h0;
    else flags_r <= (flags_r & ~flag_clear) | flag_set;  // R9
  end
  assign mode_fault_flag = flags_r[`FLAG_MODF];
  assign overrun_flag    = flags_r[`FLAG_OVR];
  assign underrun_flag   = flags_r[`FLAG_UDR];
  assign parity_err_flag = flags_r[`FLAG_PAR];

  // select decode: the active line follows its own polarity
  wire [3:0] ssl_act = in_frame ? (4'h1 << fcfg_r[`CMD_SSL]) : 4'h0;
  wire [3:0] ssl_oe_w = !master_en ? 4'h0 :
                        (multi_master ? `SSL_OE_MULTI : `SSL_OE_SINGLE);

  // pins and requests registered so every output leaves a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_clock_line_out <= 1'b0;
      serial_clock_line_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      slave_select_out <= 4'h0;
      slave_select_oe <= 4'h0;
      busy <= 1'b0;
      irq_rx_full <= 1'b0;
      irq_tx_empty <= 1'b0;
      irq_error <= 1'b0;
      irq_idle <= 1'b0;
    end else begin
      serial_clock_line_out <= sclk_r;
      serial_clock_line_oe <= master_en;
      mosi_out <= in_frame ? out_bit_r : mosi_idle_level;  // R18
      mosi_oe <= master_en;
      miso_out <= out_bit_r;
      miso_oe <= s_sel;
      slave_select_out <= ssl_act ~^ ssl_polarity;  // R15
      slave_select_oe <= ssl_oe_w;  // R10
      busy <= (state_nxt != spi_types_pkg::ST_IDLE) || s_sel;
      irq_rx_full <= rx_valid;  // R21
      irq_tx_empty <= !tx_out_valid;
      irq_error <= |flags_r;
      irq_idle <= (state_r == spi_types_pkg::ST_IDLE) && !tx_out_valid;
    end
  end

  // baud divider runs only while a master frame sequence is active
  spi_baud u_baud (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (master_en && state_r != spi_types_pkg::ST_IDLE),
    .div   (fcfg_r[`CMD_DIV]),  // R7
    .tick  (tick)
  );

  // 128-bit stores: four words on each side
  spi_fifo u_txbuf (  // R5
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (soft_init),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_ready (tx_pop)
  );
  spi_fifo u_rxbuf (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (soft_init),
    .in_valid  (rx_in_valid),
    .in_data   (rx_hold_r),
    .in_ready  (rx_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  // checks
  idle_mosi_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
    (master_en && !in_frame) |=> (mosi_out == $past(mosi_idle_level)))
    else $error("mosi not at idle level while select negated");
  single_ssl_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (master_en && !multi_master) |=> (slave_select_oe == 4'hF))
    else $error("single master must drive all select lines");
  slave_ssl_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    (!master_en || multi_master) |=> (slave_select_oe[0] == 1'b0))
    else $error("select line zero must be an input");
  frame_len_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    in_xfer |-> (((n_bits >= 6'h08 && n_bits <= 6'h10) || n_bits == 6'h14 ||
                  n_bits == 6'h18 || n_bits == 6'h20) && bit_cnt_r <= total))
    else $error("illegal frame length in transfer");
  overrun_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // R23
    (rx_in_valid && !rx_in_ready && !rx_ready && !soft_init) |=>
      (overrun_flag && !rx_in_ready))
    else $error("overrun not flagged or store changed");
  underrun_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (s_load && !tx_out_valid && !soft_init) |=> underrun_flag)
    else $error("underrun not flagged");
  autostop_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (state_r == spi_types_pkg::ST_IDLE && rx_stall) |=>
      (state_r == spi_types_pkg::ST_IDLE))
    else $error("clock started while receive store full");
  tx_only_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (transmit_only_select && fin_r && !rx_ready && !soft_init) |=>
      ($stable(rx_valid) && $stable(rx_data)))
    else $error("receive store written in transmit-only mode");
  mode_fault_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (modf_set && !soft_init) |=>
      (mode_fault_flag && state_r == spi_types_pkg::ST_IDLE) [*2])
    else $error("mode fault did not stop the master");
  start_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
    (state_r == spi_types_pkg::ST_IDLE && m_load && !soft_init) |=>
      (state_r == spi_types_pkg::ST_CKDLY) ##1
      (slave_select_out != ~ssl_polarity))
    else $error("transmit word did not start a frame");
endmodule : spi_port

// ==== spi_slave_model.sv ====
`timescale 1ns/100ps
// far-side slave device, clock mode 0; the bench sets length and order
module spi_slave_model (
  // serial pins
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  output logic             miso,
  // frame setup and captured word
  input  wire logic [5:0]  nbits,
  input  wire logic        lsb,
  input  wire logic [31:0] reply,
  output logic      [31:0] got
);
  int idx;

  initial miso = 1'b0;
  // first bit must stand before the first rising edge of the frame
  always @(negedge sel_n) begin
    idx = 0;
    got = 32'h0;
    miso = reply[lsb ? 0 : nbits - 1];
  end
  // sample on the rising edge, launch the next bit on the falling one
  always @(posedge sclk) if (!sel_n) begin
    got[lsb ? idx : nbits - 1 - idx] = mosi;
    idx++;
  end
  always @(negedge sclk) if (!sel_n && idx < nbits)
    miso = reply[lsb ? idx : nbits - 1 - idx];
  // released line has no pull: show the opposite of the last bit
  always @(posedge sel_n) miso = ~miso;
endmodule : spi_slave_model

// ==== spi_master_slave_port_tb.sv ====
`timescale 1ns/100ps
module spi_master_slave_port_tb;
  // controls start quiet; scenarios change only what they exercise
  logic clk = 1'b0, rst_n = 1'b0, master_en = 1'b1, multi_master = 1'b0;
  logic three_wire = 1'b0, transmit_only_select = 1'b0, loopback_en = 1'b0;
  logic parity_enable = 1'b0, parity_odd = 1'b0, clock_autostop_enable = 1'b0;
  logic byte_access_select = 1'b0, mosi_idle_level = 1'b1, soft_init = 1'b0;
  logic cmd_wr = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0, lsb = 1'b0;
  logic sck_in = 1'b0, mosi_drv = 1'b0, sel_in = 1'b1;
  logic [3:0]  ssl_polarity = 4'h0, flag_clear = 4'h0;
  logic [2:0]  seq_last = 3'h0, cmd_idx = 3'h0;
  logic [31:0] cmd_word = 32'h0, tx_data = 32'h0, reply = 32'h0;
  logic [5:0]  nbits = 6'h08;
  logic [31:0] rx_data, got, m, w;
  logic [3:0]  slave_select_out, slave_select_oe;
  logic        tx_ready, rx_valid, overrun_flag, underrun_flag, busy;
  logic        irq_tx_empty, irq_idle, irq_error, sclk, mosi_out, miso;
  logic        mode_fault_flag, parity_err_flag, irq_rx_full;
  logic        sck_oe, mosi_oe, miso_oe;
  logic [31:0] q[$];
  int          fail_count = 0, comparisons = 0, n, k;
  int          lens[5] = '{8, 16, 20, 24, 32};

  spi_port dut_u (
    .clk, .rst_n, .master_en, .multi_master, .three_wire,
    .transmit_only_select, .loopback_en, .parity_enable, .parity_odd,
    .clock_autostop_enable, .byte_access_select, .mosi_idle_level,
    .ssl_polarity, .seq_last, .soft_init, .cmd_wr, .cmd_idx, .cmd_word,
    .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_ready,
    .flag_clear, .mode_fault_flag, .overrun_flag, .underrun_flag,
    .parity_err_flag, .busy, .irq_rx_full, .irq_tx_empty, .irq_error,
    .irq_idle, .serial_clock_line_in(sck_in), .serial_clock_line_out(sclk),
    .serial_clock_line_oe(sck_oe), .mosi_in(mosi_drv), .mosi_out, .mosi_oe,
    .miso_in(miso), .miso_out(), .miso_oe, .slave_select_0_in(sel_in),
    .slave_select_out, .slave_select_oe);
  spi_slave_model far_u (
    .sclk, .sel_n(slave_select_out[0]), .mosi(mosi_out), .miso, .nbits,
    .lsb, .reply, .got);

  // inputs move one step after the edge so no race with the design
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // bounded wait for the sequencer to drop back to idle
  task automatic wait_idle;
    repeat (4) step;
    for (k = 0; k < 3000 && busy !== 1'b0; k++) step;
    check({31'h0, busy}, 32'h0);
  endtask : wait_idle

  // 200 MHz system clock
  initial forever #2.5 clk = ~clk;
  // watchdog: the run needs some 6 us, so 200 us means a hang
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
  // master frames of 8, 16, 20, 24 and 32 bits, then a slave frame
  initial begin
    void'($urandom(32'h18BBE8C0));
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) step;
    check({17'h0, sck_oe, mosi_oe, miso_oe, irq_rx_full, mode_fault_flag,
           parity_err_flag, tx_ready, irq_tx_empty, irq_idle, overrun_flag,
           slave_select_oe, mosi_out}, 32'h61DF);
    // receiver never drains, so the fifth frame must overrun
    for (int i = 0; i < 5; i++) begin
      n = lens[i];
      m = 32'hFFFF_FFFF >> (32 - n);
      w = $urandom();
      reply = $urandom() & m;
      nbits = n[5:0];
      lsb = i[0];
      byte_access_select = (i == 3);
      cmd_word = {14'h0, lsb, 4'(i == 0 ? 0 : i + 7), 13'h003};
      cmd_wr = 1'b1;
      step;
      cmd_wr = 1'b0;
      tx_valid = 1'b1;
      tx_data = w;
      step;
      tx_valid = 1'b0;
      wait_idle;
      // byte swap acts on the whole transmit word before the frame mask, on the receive word after it
      if (i == 3) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
      check(got, w & m);
      if (i == 3)
        reply = {reply[7:0], reply[15:8], reply[23:16], reply[31:24]};
      if (q.size() < 4) q.push_back(reply);
    end
    clock_autostop_enable = 1'b1;  // store full: no frame may start now
    check({29'h0, irq_rx_full, overrun_flag, irq_error}, 32'h7);
    repeat (4) begin
      check({31'h0, rx_valid}, 32'h1);
      check(rx_data, q.pop_front());
      rx_ready = 1'b1;
      step;
      rx_ready = 1'b0;
      step;
    end
    check({31'h0, rx_valid}, 32'h0);
    flag_clear = 4'h2;
    step;
    flag_clear = 4'h0;
    cmd_word = 32'h0000_0003;
    cmd_wr = 1'b1;
    step;
    cmd_wr = 1'b0;
    check({31'h0, overrun_flag}, 32'h0);
    master_en = 1'b0;
    parity_enable = 1'b1;
    w = $urandom() & 32'hFF;
    m = {23'h0, w[7:0], ~^w[7:0]};  // parity bit wrong on purpose
    repeat (4) step;
    check({31'h0, slave_select_oe[0]}, 32'h0);
    sel_in = 1'b0;
    repeat (8) step;
    // 125 ns serial period as 12 + 13 clocks, both halves far above two
    for (int b = 8; b >= 0; b--) begin
      mosi_drv = m[b];
      repeat (12) step;
      sck_in = 1'b1;
      repeat (13) step;
      sck_in = 1'b0;
    end
    repeat (8) step;
    check({31'h0, miso_oe}, 32'h1);
    sel_in = 1'b1;
    for (k = 0; k < 50 && rx_valid !== 1'b1; k++) step;
    check(rx_data, w);
    check({30'h0, underrun_flag, parity_err_flag}, 32'h3);
    repeat (4) step;
    soft_init = 1'b1;
    step;
    soft_init = 1'b0;
    step;
    check({27'h0, mode_fault_flag, overrun_flag, underrun_flag,
           parity_err_flag, rx_valid}, 32'h0);
    // select zero held active while multi-master is on
    master_en = 1'b1;
    multi_master = 1'b1;
    sel_in = 1'b0;
    repeat (4) step;
    check({27'h0, mode_fault_flag, slave_select_oe}, 32'h1E);
    finish_test;
  end
endmodule : spi_master_slave_port_tb
